// >>> bus_master_model.sv
// Purpose: two-wire bus master model making clock, Start and Stop
// Assumes: eight system clocks per bus clock period, pull-up on data
// Notes: bus clock stands high between frames
module bus_master_model (
	input wire clk_sys_in,
	input wire sda_in,
	output logic scl_out,
	output logic sda_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic start_cond();
		tick(4);
		sda_out = 1'b1;
		tick(2);
		scl_out = 1'b1;
		tick(4);
		sda_out = 1'b0;
		tick(4);
		scl_out = 1'b0;
	endtask
	task automatic bit_io(input logic b, output logic r);
		tick(2);
		sda_out = b;
		tick(2);
		scl_out = 1'b1;
		tick(3);
		r = sda_in;
		tick(1);
		scl_out = 1'b0;
	endtask
	task automatic stop_cond();
		tick(2);
		sda_out = 1'b0;
		tick(2);
		scl_out = 1'b1;
		tick(4);
		sda_out = 1'b1;
		tick(4);
	endtask
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic recv_byte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++) begin
			bit_io(1'b1, r);
			d = {d[6:0], r};
		end
		bit_io(~more, r);
	endtask
endmodule // bus_master_model

// >>> eeprom_front_props.sv
// Purpose: checker for the serial memory slave front end
// Assumes: bus clock low and high phases of four clocks or more
// Notes: bound to every instance of the front end
module eeprom_front_props #(parameter WRITE_CYCLES = 125000) (
	input wire clk_sys_in,
	input wire rst_in,
	input wire scl_in,
	input wire write_protect_in,
	input wire sda_oe_out,
	input wire read_strobe_out,
	input wire array_we_out,
	input wire [12:0] array_wr_addr_out,
	input wire write_busy_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int busy_cnt;
	logic [7:0] last_hi;
	logic seen;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	// count kept in helper logic: the bound is far past any repetition count
	always @(posedge clk_sys_in) begin
		busy_cnt <= (rst_in || !write_busy_out) ? 0 : busy_cnt + 1;
		seen <= (rst_in || !write_busy_out) ? 1'b0 : (seen | array_we_out);
		if (array_we_out) last_hi <= array_wr_addr_out[12:5];
	end
	chk_oe_scl_low: assert property ($changed(sda_oe_out) |-> !$past(scl_in))
		else $error("data drive changed with bus clock high");
	chk_we_in_busy: assert property (array_we_out |-> write_busy_out)
		else $error("array write outside busy window");
	chk_busy_len: assert property (busy_cnt <= WRITE_CYCLES)
		else $error("write cycle too long");
	chk_wp_blocks: assert property ($rose(write_busy_out) |-> !write_protect_in)
		else $error("write cycle under protect");
	chk_page_hold: assert property (array_we_out && seen |-> array_wr_addr_out[12:5] == last_hi)
		else $error("page write left its page");
	chk_strobe_pulse: assert property (read_strobe_out |=> !read_strobe_out)
		else $error("read strobe longer than one cycle");
	chk_no_ack_busy: assert property ($rose(sda_oe_out) |-> !write_busy_out)
		else $error("acknowledge during write cycle");
	chk_read_idle: assert property (read_strobe_out |-> !write_busy_out)
		else $error("read during write cycle");
endmodule // eeprom_front_props
bind serial_eeprom_front eeprom_front_props #(.WRITE_CYCLES(WRITE_CYCLES)) i_props (
	.clk_sys_in(clk_sys_in), .rst_in(rst_in), .scl_in(scl_in),
	.write_protect_in(write_protect_in), .sda_oe_out(sda_oe_out),
	.read_strobe_out(read_strobe_out), .array_we_out(array_we_out),
	.array_wr_addr_out(array_wr_addr_out), .write_busy_out(write_busy_out));

// >>> page_buffer.v
// Purpose: 32 byte page buffer for incoming write data
// Assumes: one write port and one read port on the system clock
// Notes: read data come out of a register, one cycle after the address
`include "serial_eeprom_map.vh"

module page_buffer (
	input wire clk_sys_in,
	input wire we_in,
	input wire [`PAGE_IDX_W-1:0] waddr_in,
	input wire [7:0] wdata_in,
	input wire [`PAGE_IDX_W-1:0] raddr_in,
	output reg [7:0] rdata_out
);
	reg [7:0] mem [0:`PAGE_BYTES-1];

	always @(posedge clk_sys_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
		rdata_out <= mem[raddr_in];
	end
endmodule // page_buffer

// >>> serial_eeprom_front.v
// Purpose: two-wire slave front end of a 64 kbit serial memory
// Assumes: bus pins and straps are asynchronous and are synchronised here
// Notes: array reached through read strobe and write port signals
`include "serial_eeprom_map.vh"

module serial_eeprom_front #(
	parameter WRITE_CYCLES = `WRITE_CYCLES
) (
	input wire clk_sys_in,
	input wire rst_in,
	input wire scl_in,
	input wire sda_in,
	input wire chip_select_pin_0_in,
	input wire chip_select_pin_1_in,
	input wire chip_select_pin_2_in,
	input wire write_protect_in,
	input wire [7:0] read_data_in,
	output reg sda_out,
	output reg sda_oe_out,
	output reg [`ADDR_W-1:0] word_address_out,
	output reg read_strobe_out,
	output reg array_we_out,
	output reg [`ADDR_W-1:0] array_wr_addr_out,
	output reg [7:0] array_wr_data_out,
	output reg write_busy_out
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_CTRL = 3'h1;
	localparam [2:0] ST_ADDR_HI = 3'h2;
	localparam [2:0] ST_ADDR_LO = 3'h3;
	localparam [2:0] ST_WDATA = 3'h4;
	localparam [2:0] ST_RDATA = 3'h5;
	localparam [2:0] ST_IGNORE = 3'h6;
	// counts kept in 32 bits, then cut to the counter width on purpose
	localparam integer WRITE_LAST_INT = WRITE_CYCLES - 1;
	localparam integer STREAM_END_INT = `PAGE_BYTES;
	localparam [`WRITE_CNT_W-1:0] WRITE_LAST = WRITE_LAST_INT[`WRITE_CNT_W-1:0];
	localparam [`WRITE_CNT_W-1:0] STREAM_END = STREAM_END_INT[`WRITE_CNT_W-1:0];

	function ctrl_hit;
		input [7:0] ctrl;
		input [2:0] pins;
		begin
			ctrl_hit = (ctrl[`CTRL_CODE_MSB:`CTRL_CODE_LSB] == `CTRL_CODE) &&
				(ctrl[`CTRL_CS_MSB:`CTRL_CS_LSB] == pins);
		end
	endfunction

	// ninth pulse of a byte: the acknowledge slot
	function at_ack_slot;
		input [3:0] cnt;
		begin
			at_ack_slot = (cnt == `BITS_PER_BYTE);
		end
	endfunction

	// two stage synchronisers, plus a third stage for edge detection
	wire [5:0] pins_raw;
	reg [5:0] sync1_reg;
	reg [5:0] sync2_reg;
	reg scl_d_reg;
	reg sda_d_reg;
	assign pins_raw = {write_protect_in, chip_select_pin_2_in, chip_select_pin_1_in,
		chip_select_pin_0_in, sda_in, scl_in};

	// reset to the idle level so the release shows no false Start
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
			always @(posedge clk_sys_in) begin
				if (rst_in) begin
					sync1_reg[gi] <= 1'b1;
					sync2_reg[gi] <= 1'b1;
				end else begin
					sync1_reg[gi] <= pins_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	wire scl_s;
	wire sda_s;
	wire [2:0] cs_pins_s;
	wire wp_s;
	assign scl_s = sync2_reg[0];
	assign sda_s = sync2_reg[1];
	assign cs_pins_s = sync2_reg[4:2];
	assign wp_s = sync2_reg[5];

	always @(posedge clk_sys_in) begin
		if (rst_in) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	wire scl_rise;
	wire scl_fall;
	wire start_det;
	wire stop_det;
	assign scl_rise = scl_s & ~scl_d_reg;
	assign scl_fall = ~scl_s & scl_d_reg;
	assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	reg [2:0] state_reg;
	reg [3:0] bit_cnt_reg;
	reg [7:0] rx_reg;
	reg [7:0] tx_reg;
	reg ack_want_reg;
	reg [4:0] addr_hi_reg;
	reg [`ADDR_W-`PAGE_IDX_W-1:0] page_reg;
	reg [`PAGE_BYTES-1:0] valid_reg;
	reg got_data_reg;
	reg commit_reg;
	reg rd_load_reg;
	reg buf_we_reg;
	reg [`PAGE_IDX_W-1:0] buf_waddr_reg;
	reg [7:0] buf_wdata_reg;
	reg [`WRITE_CNT_W-1:0] cyc_cnt_reg;
	reg stream_go_reg;
	reg [`PAGE_IDX_W-1:0] stream_idx_reg;
	wire [7:0] buf_rdata;
	wire [7:0] byte_in;
	wire busy_any;

	assign byte_in = {rx_reg[6:0], sda_s};
	// a command in the cycle between Stop and busy is refused too
	assign busy_any = write_busy_out | commit_reg;

	page_buffer u_page_buffer (
		.clk_sys_in(clk_sys_in),
		.we_in(buf_we_reg),
		.waddr_in(buf_waddr_reg),
		.wdata_in(buf_wdata_reg),
		.raddr_in(cyc_cnt_reg[`PAGE_IDX_W-1:0]),
		.rdata_out(buf_rdata)
	);

	// bus protocol engine
	always @(posedge clk_sys_in) begin
		if (rst_in) begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
			rx_reg <= 8'h00;
			tx_reg <= 8'hff;
			ack_want_reg <= 1'b0;
			addr_hi_reg <= 5'h00;
			page_reg <= 8'h00;
			valid_reg <= 32'h00000000;
			got_data_reg <= 1'b0;
			commit_reg <= 1'b0;
			rd_load_reg <= 1'b0;
			buf_we_reg <= 1'b0;
			buf_waddr_reg <= 5'h00;
			buf_wdata_reg <= 8'h00;
			word_address_out <= `ADDR_RESET;
			read_strobe_out <= 1'b0;
			sda_out <= 1'b0;
			sda_oe_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
			read_strobe_out <= 1'b0;
			commit_reg <= 1'b0;
			buf_we_reg <= 1'b0;
			rd_load_reg <= read_strobe_out;
			// array answers one cycle after the strobe
			if (rd_load_reg) begin
				tx_reg <= read_data_in;
				// full 13 bit increment, rolls over at the top of the array
				word_address_out <= word_address_out + 13'h0001;
			end
			if (start_det) begin
				state_reg <= ST_CTRL;
				bit_cnt_reg <= 4'h0;
				sda_oe_out <= 1'b0;
				ack_want_reg <= 1'b0;
				got_data_reg <= 1'b0;
				// a repeated start drops unfinished write data
				if (!write_busy_out) begin
					valid_reg <= 32'h00000000;
				end
			end else if (stop_det) begin
				state_reg <= ST_IDLE;
				sda_oe_out <= 1'b0;
				ack_want_reg <= 1'b0;
				got_data_reg <= 1'b0;
				if (state_reg == ST_WDATA && got_data_reg) begin
					if (wp_s) begin
						valid_reg <= 32'h00000000;
					end else begin
						commit_reg <= 1'b1;
					end
				end
			end else begin
				if (scl_rise && state_reg != ST_IDLE) begin
					if (!at_ack_slot(bit_cnt_reg)) begin
						rx_reg <= byte_in;
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else begin
						bit_cnt_reg <= 4'h0;
						// the control byte's own acknowledge must not fetch a second byte
						if (state_reg == ST_RDATA && !ack_want_reg) begin
							if (sda_s) begin
								state_reg <= ST_IGNORE;
							end else begin
								read_strobe_out <= 1'b1;
							end
						end
					end
					if (bit_cnt_reg == 4'h7) begin
						ack_want_reg <= 1'b0;
						case (state_reg)
							ST_CTRL: begin
								if (ctrl_hit(byte_in, cs_pins_s) && !busy_any) begin
									ack_want_reg <= 1'b1;
									if (byte_in[`CTRL_RW_BIT]) begin
										state_reg <= ST_RDATA;
										read_strobe_out <= 1'b1;
									end else begin
										state_reg <= ST_ADDR_HI;
									end
								end else begin
									state_reg <= ST_IGNORE;
								end
							end
							ST_ADDR_HI: begin
								addr_hi_reg <= byte_in[4:0];
								ack_want_reg <= 1'b1;
								state_reg <= ST_ADDR_LO;
							end
							ST_ADDR_LO: begin
								word_address_out <= {addr_hi_reg, byte_in};
								page_reg <= {addr_hi_reg, byte_in[7:5]};
								ack_want_reg <= 1'b1;
								state_reg <= ST_WDATA;
							end
							ST_WDATA: begin
								// page wraps, so the oldest byte is overwritten first
								buf_we_reg <= 1'b1;
								buf_waddr_reg <= word_address_out[`PAGE_IDX_W-1:0];
								buf_wdata_reg <= byte_in;
								valid_reg[word_address_out[`PAGE_IDX_W-1:0]] <= 1'b1;
								word_address_out[`PAGE_IDX_W-1:0] <=
									word_address_out[`PAGE_IDX_W-1:0] + 5'h01;
								got_data_reg <= 1'b1;
								ack_want_reg <= 1'b1;
							end
							default: begin
								ack_want_reg <= 1'b0;
							end
						endcase
					end
				end
				// drive changes wait for a seen clock low edge, except the release at Start and Stop
				if (scl_fall) begin
					if (at_ack_slot(bit_cnt_reg)) begin
						sda_oe_out <= ack_want_reg & ~busy_any;
					end else if (state_reg == ST_RDATA) begin
						sda_oe_out <= ~tx_reg[3'h7 - bit_cnt_reg[2:0]];
					end else begin
						sda_oe_out <= 1'b0;
					end
				end
			end
		end
	end

	// self-timed array write: stream valid bytes, then hold busy to the end
	always @(posedge clk_sys_in) begin
		if (rst_in) begin
			write_busy_out <= 1'b0;
			cyc_cnt_reg <= {`WRITE_CNT_W{1'b0}};
			stream_go_reg <= 1'b0;
			stream_idx_reg <= 5'h00;
			array_we_out <= 1'b0;
			array_wr_addr_out <= `ADDR_RESET;
			array_wr_data_out <= 8'h00;
		end else begin
			// buffer read is registered, so enable and index trail the count by one
			stream_go_reg <= write_busy_out && (cyc_cnt_reg < STREAM_END);
			stream_idx_reg <= cyc_cnt_reg[`PAGE_IDX_W-1:0];
			array_we_out <= stream_go_reg & valid_reg[stream_idx_reg];
			array_wr_addr_out <= {page_reg, stream_idx_reg};
			array_wr_data_out <= buf_rdata;
			if (commit_reg) begin
				write_busy_out <= 1'b1;
				cyc_cnt_reg <= {`WRITE_CNT_W{1'b0}};
			end else if (write_busy_out) begin
				if (cyc_cnt_reg == WRITE_LAST) begin
					write_busy_out <= 1'b0;
				end else begin
					cyc_cnt_reg <= cyc_cnt_reg + {{(`WRITE_CNT_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // serial_eeprom_front

// >>> serial_eeprom_map.vh
// Purpose: constants shared by the serial memory slave front end
// Assumes: system clock of 25 MHz; bus lines sampled, never used as a clock
// Notes: timing counts derive from times in their own unit
`ifndef SERIAL_EEPROM_MAP_VH
`define SERIAL_EEPROM_MAP_VH

`define CTRL_CODE 4'ha
`define CTRL_CODE_MSB 7
`define CTRL_CODE_LSB 4
`define CTRL_CS_MSB 3
`define CTRL_CS_LSB 1
`define CTRL_RW_BIT 0
`define ADDR_W 13
`define PAGE_IDX_W 5
`define PAGE_BYTES 32
`define BITS_PER_BYTE 4'h8
`define ADDR_RESET 13'h0000
`define CLK_FREQ_MHZ 25
`define WRITE_TIME_US 5000
`define WRITE_CYCLES (`WRITE_TIME_US * `CLK_FREQ_MHZ)
`define WRITE_CNT_W 17

`endif

// >>> tb_serial_eeprom_i2c_slave_front.sv
// Purpose: bench for the serial memory slave front end
// Assumes: bus master model on the far side, pull-up on data
// Notes: short write time so the busy window fits the run
module tb_serial_eeprom_i2c_slave_front;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WC = 400;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic [2:0] pins = 3'b101;
	logic wp = 1'b0;
	logic [7:0] rd_data = 8'h00;
	logic [7:0] pg [0:31];
	logic [7:0] we_hi;
	wire m_scl, m_sda, s_out, s_oe, rd_stb, we, busy;
	wire [12:0] waddr, wr_addr;
	wire [7:0] wr_data;
	wire sda_line = (s_oe ? s_out : 1'b1) & m_sda;
	int num_errors = 0;
	int samples_checked = 0;
	int we_count = 0;
	int cycles = 0;
	always #20 clk_sys_in = ~clk_sys_in;
	serial_eeprom_front #(.WRITE_CYCLES(WC)) i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.scl_in(m_scl), .sda_in(sda_line), .chip_select_pin_0_in(pins[0]),
		.chip_select_pin_1_in(pins[1]), .chip_select_pin_2_in(pins[2]),
		.write_protect_in(wp), .read_data_in(rd_data), .sda_out(s_out), .sda_oe_out(s_oe),
		.word_address_out(waddr), .read_strobe_out(rd_stb), .array_we_out(we),
		.array_wr_addr_out(wr_addr), .array_wr_data_out(wr_data), .write_busy_out(busy));
	bus_master_model i_master (.clk_sys_in(clk_sys_in), .sda_in(sda_line), .scl_out(m_scl),
		.sda_out(m_sda));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// array stand-in answers the cycle after the strobe
	always @(posedge clk_sys_in) begin
		cycles++;
		if (rd_stb === 1'b1) rd_data <= waddr[7:0] ^ 8'h3c;
		if (we === 1'b1) begin
			pg[wr_addr[4:0]] = wr_data;
			we_hi = wr_addr[12:5];
			we_count++;
		end
		if (cycles == 20000) begin
			num_errors++;
			end_of_test();
		end
	end
	task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic addr_cmd(input logic [7:0] h, input logic [7:0] l, output int n);
		logic a;
		i_master.start_cond();
		i_master.send_byte(8'haa, a);
		n = a;
		i_master.send_byte(h, a);
		n += a;
		i_master.send_byte(l, a);
		n += a;
	endtask
	task automatic wait_idle();
		for (int k = 0; k < 1000 && busy !== 1'b0; k++) @(posedge clk_sys_in);
		#1;
		check("busy", 0, busy);
	endtask
	task automatic t_select();
		logic [7:0] ctl [4] = '{8'hb0, 8'ha0, 8'hac, 8'haa};
		logic a;
		for (int i = 0; i < 4; i++) begin
			i_master.start_cond();
			i_master.send_byte(ctl[i], a);
			i_master.stop_cond();
			check("select ack", i == 3, a);
		end
		pins = 3'b000;
		i_master.start_cond();
		i_master.send_byte(8'ha0, a);
		i_master.stop_cond();
		check("zero select ack", 1, a);
		pins = 3'b101;
	endtask
	task automatic t_page();
		int n;
		int j;
		logic a;
		we_count = 0;
		addr_cmd(8'hff, 8'h3c, n);
		for (int i = 0; i < 34; i++) begin
			i_master.send_byte(8'h40 + i[7:0], a);
			n += a;
		end
		i_master.stop_cond();
		check("write acks", 37, n);
		i_master.start_cond();
		i_master.send_byte(8'haa, a);
		i_master.stop_cond();
		check("poll ack", 0, a);
		wait_idle();
		check("bytes written", 32, we_count);
		check("page", 8'hf9, we_hi);
		for (int k = 0; k < 32; k++) begin
			j = (k + 4) % 32;
			check("page byte", 8'h40 + j[7:0] + (j < 2 ? 8'h20 : 8'h00), pg[k]);
		end
	endtask
	task automatic t_read();
		int n;
		logic a;
		logic [7:0] d;
		wp = 1'b1;
		addr_cmd(8'h00, 8'h10, n);
		i_master.start_cond();
		i_master.send_byte(8'hab, a);
		check("read acks", 4, n + a);
		i_master.recv_byte(1'b1, d);
		check("read 0", 8'h10 ^ 8'h3c, d);
		i_master.recv_byte(1'b0, d);
		check("read 1", 8'h11 ^ 8'h3c, d);
		i_master.stop_cond();
		check("release", 0, s_oe);
		check("busy", 0, busy);
		check("pointer", 16'h0012, waddr);
		wp = 1'b0;
	endtask
	task automatic t_protect();
		int n;
		logic a;
		for (int p = 0; p < 2; p++) begin
			we_count = 0;
			wp = (p == 0);
			addr_cmd(8'h00, 8'h40, n);
			i_master.send_byte(8'h77, a);
			i_master.stop_cond();
			repeat (8) @(posedge clk_sys_in);
			#1;
			wp = 1'b1;
			repeat (12) @(posedge clk_sys_in);
			#1;
			check("busy", p, busy);
			wait_idle();
			check("writes", p, we_count);
			check("acks", 4, n + a);
		end
		wp = 1'b0;
	endtask
	initial begin
		repeat (5) @(posedge clk_sys_in);
		#1;
		rst_in = 1'b0;
		repeat (3) @(posedge clk_sys_in);
		#1;
		check("oe", 0, s_oe);
		t_select();
		t_page();
		t_read();
		t_protect();
		end_of_test();
	end
endmodule // tb_serial_eeprom_i2c_slave_front
